// >>> rtl/lpa_arbiter.sv
`timescale 1ns/1ps
// Low-power mode entry arbiter top
// Operation
// - Class state by clock above or below 50kHz
// - Demote request to deepest mode peripherals allow when no external clock is used
// - DMA trigger returns to active for transfer
// - CRC, multiplier, AES busy delay low-power entry
// - Serial A UART: idle unclocked, sub HF, aux LF
// - Serial B I2C target: unclocked waiting or slow
// - Timers: sub/fast-ext HF, aux LF, slow-ext unclocked
// - Converter: sub/module-osc HF, aux LF, waiting unclocked
// - Scan interface: sub HF, aux/scan-osc LF
// - Segment driver only ever low-frequency
// - SPI/I2C target classed by external bit clock
// - Report powered idle-current groups in deep standby
// - Interrupt wakes, handler runs, prior mode resumes
module lpa_arbiter
(
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rstn,
    // CPU mode request
    input  wire logic                            req_valid,
    input  wire lpa_pkg::lpa_mode_t              req_mode,
    input  wire logic                            irq_pend,
    input  wire logic                            irq_exit,
    // Peripheral reports
    input  wire logic [lpa_pkg::LPA_NPER-1:0]    per_active,
    input  wire logic [lpa_pkg::LPA_NPER*3-1:0]  per_src,
    input  wire logic [lpa_pkg::LPA_NPER*32-1:0] per_ext_hz,
    input  wire logic                            sua_spi,
    input  wire logic                            sub_spi,
    input  wire logic                            dma_trig,
    input  wire logic                            dma_done,
    input  wire logic                            crc_busy,
    input  wire logic                            mul_busy,
    input  wire logic                            aes_busy,
    // Status
    output lpa_pkg::lpa_mode_t                   cur_mode,
    output logic                                 in_isr,
    output logic                                 dma_xfer,
    output logic                                 entry_hold,
    output logic [lpa_pkg::LPA_NGROUP-1:0]       group_pwr
);
    import lpa_pkg::*;

    typedef enum logic [3:0] {
        LPA_S_RUN  = 4'h1,
        LPA_S_WAIT = 4'h2,
        LPA_S_LPM  = 4'h4,
        LPA_S_WAKE = 4'h8
    } lpa_fsm_t;

    lpa_cls_if cls_bus ();

    lpa_classify u_cls (
        .per_active (per_active),
        .per_src    (per_src),
        .per_ext_hz (per_ext_hz),
        .sua_spi    (sua_spi),
        .sub_spi    (sub_spi),
        .cls        (cls_bus.cls)
    );

    // Deepest mode each state allows
    function automatic lpa_mode_t cap_of(input lpa_state_t s);
        case (s)
            LPA_ST_HF:   cap_of = LPA_CPUOFF1;
            LPA_ST_LF:   cap_of = LPA_STBY3;
            default:     cap_of = LPA_OFF4;
        endcase
    endfunction : cap_of

    lpa_mode_t              cap;
    logic                   any_ext;
    logic [LPA_NGROUP-1:0]  grp_use;

    always_comb begin
        cap     = LPA_OFF4;
        any_ext = 1'b0;
        grp_use = '0;
        for (int i = 0; i < LPA_NPER; i++) begin
            if (cap_of(cls_bus.st[i]) < cap)
                cap = cap_of(cls_bus.st[i]);
            if (cls_bus.st[i] != LPA_ST_NONE)
                grp_use = grp_use | LPA_GROUP_MAP[i*4 +: 4];
            any_ext = any_ext | cls_bus.ext_used[i];
        end
    end

    logic busy_core;
    assign busy_core = crc_busy | mul_busy | aes_busy;

    lpa_fsm_t   st_r, st_nxt;
    lpa_mode_t  mode_r, mode_nxt;
    lpa_mode_t  sleep_r, sleep_nxt;
    lpa_mode_t  pend_r, pend_nxt;
    logic       isr_r, isr_nxt;
    logic       dma_r, dma_nxt;
    logic       hold_r, hold_nxt;
    logic [LPA_NGROUP-1:0] grp_r, grp_nxt;

    // Grant: external clock bypasses the demotion, application owns the range
    function automatic lpa_mode_t grant(input lpa_mode_t r, input lpa_mode_t c, input logic ext);
        grant = (!ext && r > c) ? c : r;
    endfunction : grant

    always_comb begin
        st_nxt    = st_r;
        mode_nxt  = mode_r;
        sleep_nxt = sleep_r;
        pend_nxt  = pend_r;
        isr_nxt   = isr_r;
        dma_nxt   = dma_r;
        hold_nxt  = 1'b0;
        case (st_r)
            LPA_S_RUN: begin
                if (irq_exit && isr_r) begin
                    isr_nxt  = 1'b0;
                    if (sleep_r != LPA_ACTIVE) begin
                        pend_nxt = sleep_r;
                        st_nxt   = LPA_S_WAIT;
                    end
                end else if (req_valid && req_mode != LPA_ACTIVE && !isr_r) begin
                    pend_nxt = req_mode;
                    st_nxt   = LPA_S_WAIT;
                end
            end
            LPA_S_WAIT: begin
                // Entry postponed, active-only units must finish first
                if (busy_core) begin
                    hold_nxt = 1'b1;
                end else begin
                    mode_nxt  = grant(pend_r, cap, any_ext);
                    sleep_nxt = pend_r;
                    st_nxt    = LPA_S_LPM;
                end
            end
            LPA_S_LPM: begin
                // Re-arbitrate so a new peripheral state cannot be starved
                mode_nxt = grant(sleep_r, cap, any_ext);
                if (irq_pend) begin
                    mode_nxt = LPA_ACTIVE;
                    isr_nxt  = 1'b1;
                    st_nxt   = LPA_S_RUN;
                end else if (dma_trig) begin
                    mode_nxt = LPA_ACTIVE;
                    dma_nxt  = 1'b1;
                    st_nxt   = LPA_S_WAKE;
                end
            end
            LPA_S_WAKE: begin
                if (dma_done) begin
                    dma_nxt  = 1'b0;
                    mode_nxt = grant(sleep_r, cap, any_ext);
                    st_nxt   = LPA_S_LPM;
                end
            end
            default: begin
                st_nxt   = LPA_S_RUN;
                mode_nxt = LPA_ACTIVE;
            end
        endcase
        if (st_nxt == LPA_S_RUN && st_r != LPA_S_RUN)
            sleep_nxt = sleep_r;
        // Group power only matters in the deep standby modes
        grp_nxt = (mode_nxt >= LPA_STBY3) ? grp_use : '0;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r    <= LPA_S_RUN;
            mode_r  <= LPA_ACTIVE;
            sleep_r <= LPA_ACTIVE;
            pend_r  <= LPA_ACTIVE;
            isr_r   <= 1'b0;
            dma_r   <= 1'b0;
            hold_r  <= 1'b0;
            grp_r   <= '0;
        end else begin
            st_r    <= st_nxt;
            mode_r  <= mode_nxt;
            sleep_r <= sleep_nxt;
            pend_r  <= pend_nxt;
            isr_r   <= isr_nxt;
            dma_r   <= dma_nxt;
            hold_r  <= hold_nxt;
            grp_r   <= grp_nxt;
        end
    end

    assign cur_mode   = mode_r;
    assign in_isr     = isr_r;
    assign dma_xfer   = dma_r;
    assign entry_hold = hold_r;
    assign group_pwr  = grp_r;

    // Checks
    hf_cap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAIT && !busy_core && !any_ext && cap == LPA_CPUOFF1)
        |=> (mode_r <= LPA_CPUOFF1))
        else $error("High-frequency peripheral allowed deep mode");
    demote_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAIT && !busy_core && !any_ext && pend_r > cap) |=> (mode_r == $past(cap)))
        else $error("Request not demoted to supported mode");
    ext_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAIT && !busy_core && any_ext) |=> (mode_r == $past(pend_r)))
        else $error("External clock request was altered");
    busy_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAIT && busy_core) |=> (entry_hold && st_r == LPA_S_WAIT && mode_r == $past(mode_r)))
        else $error("Low-power entry while unit busy");
    dma_wake_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_LPM && dma_trig && !irq_pend) |=> (dma_xfer && mode_r == LPA_ACTIVE))
        else $error("DMA trigger did not wake to active");
    dma_back_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAKE && dma_done) |=> (!dma_xfer && st_r == LPA_S_LPM))
        else $error("No return after DMA transfer");
    irq_wake_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_LPM && irq_pend) |=> (in_isr && mode_r == LPA_ACTIVE))
        else $error("Interrupt did not wake device");
    irq_ret_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_RUN && isr_r && irq_exit && sleep_r != LPA_ACTIVE)
        |=> (st_r == LPA_S_WAIT && pend_r == $past(sleep_r)))
        else $error("Handler exit did not resume prior mode");
    grp_pwr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode_r < LPA_STBY3) |-> (group_pwr == '0))
        else $error("Group powered outside deep standby");

    // Grant limits
    lf_cap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAIT && !busy_core && !any_ext && cap == LPA_STBY3)
        |=> (mode_r <= LPA_STBY3))
        else $error("Low-frequency peripheral allowed off mode");

    req_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAIT && !busy_core && !any_ext && pend_r <= cap)
        |=> (mode_r == $past(pend_r)))
        else $error("Supported request was changed");

    lpm_cap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_LPM && !irq_pend && !dma_trig && !any_ext)
        |=> (mode_r <= $past(cap)))
        else $error("Sleeping mode exceeds peripheral limit");

    lpm_ext_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_LPM && !irq_pend && !dma_trig && any_ext)
        |=> (mode_r == $past(sleep_r)))
        else $error("External clock mode altered while asleep");

    // Request intake
    req_take_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_RUN && !isr_r && req_valid && req_mode != LPA_ACTIVE)
        |=> (st_r == LPA_S_WAIT && pend_r == $past(req_mode)))
        else $error("Mode request not taken");

    idle_run_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_RUN && !isr_r && (!req_valid || req_mode == LPA_ACTIVE))
        |=> (st_r == LPA_S_RUN && mode_r == LPA_ACTIVE))
        else $error("Active mode left without request");

    // Postponed entry
    hold_wait_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        entry_hold |-> (st_r == LPA_S_WAIT))
        else $error("Entry hold outside waiting state");

    busy_go_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAIT && !busy_core)
        |=> (!entry_hold && st_r == LPA_S_LPM))
        else $error("Entry not taken once units idle");

    // Wakeups
    dma_act_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        dma_xfer |-> (mode_r == LPA_ACTIVE))
        else $error("Transfer outside active mode");

    dma_stay_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_WAKE && !dma_done)
        |=> (dma_xfer && mode_r == LPA_ACTIVE))
        else $error("Transfer cut short");

    isr_act_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        in_isr |-> (mode_r == LPA_ACTIVE))
        else $error("Handler running outside active mode");

    irq_first_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_LPM && irq_pend && dma_trig)
        |=> (in_isr && !dma_xfer))
        else $error("Interrupt lost to transfer trigger");

    isr_stay_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == LPA_S_RUN && isr_r && !irq_exit)
        |=> (st_r == LPA_S_RUN && in_isr))
        else $error("Handler left without exit");

    // Peripheral classes
    lcd_lf_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cls_bus.st[LPA_P_LCD] != LPA_ST_HF && cls_bus.st[LPA_P_LCD] != LPA_ST_UNCK))
        else $error("Segment driver left low-frequency state");

    scan_clk_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cls_bus.st[LPA_P_SCAN] != LPA_ST_UNCK))
        else $error("Scan interface classed unclocked");

    tmr_slow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cls_bus.ext_used[LPA_P_TMA] && per_ext_hz[LPA_P_TMA*32 +: 32] <= LPA_LF_MAX_HZ)
        |-> (cls_bus.st[LPA_P_TMA] == LPA_ST_UNCK))
        else $error("Slow external timer clock not unclocked");

    grp_deep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (mode_r >= LPA_STBY3 && $past(cls_bus.st[LPA_P_LCD]) != LPA_ST_NONE)
        |-> ((group_pwr & LPA_GROUP_MAP[LPA_P_LCD*4 +: 4]) != '0))
        else $error("Active member group not powered");
endmodule : lpa_arbiter

// >>> rtl/lpa_classify.sv
`timescale 1ns/1ps
// Per-peripheral clock state classifier
module lpa_classify
(
    // Peripheral reports
    input  wire logic [lpa_pkg::LPA_NPER-1:0]    per_active,
    input  wire logic [lpa_pkg::LPA_NPER*3-1:0]  per_src,
    input  wire logic [lpa_pkg::LPA_NPER*32-1:0] per_ext_hz,
    input  wire logic                            sua_spi,
    input  wire logic                            sub_spi,
    // Result
    lpa_cls_if.cls                               cls
);
    import lpa_pkg::*;

    // Threshold classing of an external clock
    function automatic lpa_state_t ext_class(input logic [31:0] hz, input lpa_state_t low);
        ext_class = (hz > LPA_LF_MAX_HZ) ? LPA_ST_HF : low;
    endfunction : ext_class

    always_comb begin
        for (int i = 0; i < LPA_NPER; i++) begin
            logic [2:0]  s;
            logic [31:0] hz;
            s  = per_src[i*3 +: 3];
            hz = per_ext_hz[i*32 +: 32];
            cls.st[i]       = LPA_ST_NONE;
            cls.ext_used[i] = per_active[i] && (s == LPA_SRC_EXT);
            if (per_active[i]) begin
                case (s)
                    LPA_SRC_SUB:  cls.st[i] = (i == LPA_P_LCD) ? LPA_ST_LF : LPA_ST_HF;
                    LPA_SRC_MOD:  cls.st[i] = (i == LPA_P_LCD) ? LPA_ST_LF : LPA_ST_HF;
                    LPA_SRC_AUX, LPA_SRC_VLO, LPA_SRC_SCAN: cls.st[i] = LPA_ST_LF;
                    LPA_SRC_WAIT: cls.st[i] = (i == LPA_P_SCAN || i == LPA_P_LCD) ? LPA_ST_LF : LPA_ST_UNCK;
                    LPA_SRC_EXT: begin
                        if (i == LPA_P_TMA || i == LPA_P_TMB)
                            cls.st[i] = ext_class(hz, LPA_ST_UNCK);
                        else if (i == LPA_P_LCD)
                            cls.st[i] = LPA_ST_LF;
                        else if (i == LPA_P_SUB)
                            cls.st[i] = ext_class(hz, sub_spi ? LPA_ST_LF : LPA_ST_UNCK);
                        else if (i == LPA_P_SUA && sua_spi)
                            cls.st[i] = ext_class(hz, LPA_ST_LF);
                        else
                            cls.st[i] = ext_class(hz, LPA_ST_LF);
                    end
                    default:      cls.st[i] = LPA_ST_NONE;
                endcase
            end
        end
    end
endmodule : lpa_classify

// >>> rtl/lpa_if.sv
`timescale 1ns/1ps
// Classifier to arbiter carrier
interface lpa_cls_if;
    import lpa_pkg::*;
    lpa_state_t             st [LPA_NPER];
    logic [LPA_NPER-1:0]    ext_used;
    modport cls (output st, output ext_used);
    modport arb (input st, input ext_used);
endinterface : lpa_cls_if

// >>> rtl/lpa_pkg.sv
// Package for the low-power mode entry arbiter
package lpa_pkg;
    // Power modes, ordered shallow to deep
    typedef enum logic [2:0] {
        LPA_ACTIVE  = 3'h0,
        LPA_CPUOFF0 = 3'h1,
        LPA_CPUOFF1 = 3'h2,
        LPA_STBY2   = 3'h3,
        LPA_STBY3   = 3'h4,
        LPA_OFF4    = 3'h5
    } lpa_mode_t;

    // Peripheral clock state
    typedef enum logic [1:0] {
        LPA_ST_NONE = 2'h0,
        LPA_ST_UNCK = 2'h1,
        LPA_ST_LF   = 2'h2,
        LPA_ST_HF   = 2'h3
    } lpa_state_t;

    // Clock source codes reported by peripherals
    localparam logic [2:0] LPA_SRC_OFF  = 3'h0;
    localparam logic [2:0] LPA_SRC_SUB  = 3'h1;
    localparam logic [2:0] LPA_SRC_AUX  = 3'h2;
    localparam logic [2:0] LPA_SRC_EXT  = 3'h3;
    localparam logic [2:0] LPA_SRC_MOD  = 3'h4;
    localparam logic [2:0] LPA_SRC_VLO  = 3'h5;
    localparam logic [2:0] LPA_SRC_SCAN = 3'h6;
    localparam logic [2:0] LPA_SRC_WAIT = 3'h7;

    // Frequency threshold in Hz
    localparam int unsigned LPA_LF_MAX_HZ = 50000;

    // Peripheral slots in the report vector
    localparam int LPA_P_WDOG = 0;
    localparam int LPA_P_TMA  = 1;
    localparam int LPA_P_TMB  = 2;
    localparam int LPA_P_SUA  = 3;
    localparam int LPA_P_SUB  = 4;
    localparam int LPA_P_ADC  = 5;
    localparam int LPA_P_SCAN = 6;
    localparam int LPA_P_LCD  = 7;
    localparam int LPA_NPER   = 8;
    localparam int LPA_NGROUP = 4;

    // Group membership per slot (bit g set: slot in group g)
    localparam logic [LPA_NPER*4-1:0] LPA_GROUP_MAP = 32'h8214_4410;
endpackage : lpa_pkg

// >>> sim/lpa_per_model.sv
// Peripheral clock report model for the arbiter bench
`timescale 1ns/1ps
module lpa_per_model
    import lpa_pkg::*;
(
    // Peripheral reports
    output logic [LPA_NPER-1:0]    per_active,
    output logic [LPA_NPER*3-1:0]  per_src,
    output logic [LPA_NPER*32-1:0] per_ext_hz,
    // Serial target modes
    output logic                   sua_spi,
    output logic                   sub_spi
);
    initial begin
        clear_all();
    end

    // All slots idle, no external clocks
    task automatic clear_all();
        per_active = '0;
        per_src    = '0;
        per_ext_hz = '0;
        sua_spi    = 1'b0;
        sub_spi    = 1'b0;
    endtask : clear_all

    // Application picks the external rate; nothing here corrects it
    task automatic set_slot(input int s, input logic [2:0] src, input int unsigned hz);
        per_active[s]          = 1'b1;
        per_src[s*3 +: 3]      = src;
        per_ext_hz[s*32 +: 32] = hz;
    endtask : set_slot
endmodule : lpa_per_model

// >>> sim/tb.sv
// Self-checking bench for the low-power mode entry arbiter
`timescale 1ns/1ps
module tb;
    import lpa_pkg::*;
    logic                   sys_clk    = 1'b0;
    logic                   rstn       = 1'b0;
    logic                   req_valid  = 1'b0;
    lpa_mode_t              req_mode   = LPA_ACTIVE;
    logic                   irq_pend   = 1'b0;
    logic                   irq_exit   = 1'b0;
    logic                   dma_trig   = 1'b0;
    logic                   dma_done   = 1'b0;
    logic [2:0]             busy       = 3'h0;
    logic [LPA_NPER-1:0]    per_active;
    logic [LPA_NPER*3-1:0]  per_src;
    logic [LPA_NPER*32-1:0] per_ext_hz;
    logic                   sua_spi;
    logic                   sub_spi;
    lpa_mode_t              cur_mode;
    logic                   in_isr;
    logic                   dma_xfer;
    logic                   entry_hold;
    logic [3:0]             group_pwr;
    int                     mismatches = 0;
    int                     checks     = 0;
    // Cases: slot, source code, ext Hz, requested and granted mode
    int c_slot[16] = '{0, 0, 0, 1, 3, 3, 3, 4, 5, 5, 5, 6, 6, 7, 2, 1};
    int c_src[16]  = '{1, 1, 2, 3, 7, 1, 2, 7, 4, 7, 2, 6, 1, 5, 1, 3};
    int c_hz[16]   = '{0, 0, 0, 60000, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 40000};
    int c_req[16]  = '{5, 1, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 5};
    int c_exp[16]  = '{2, 1, 4, 5, 5, 2, 4, 5, 2, 5, 4, 4, 2, 4, 2, 5};

    always #12.5 sys_clk = ~sys_clk;

    lpa_per_model u_per (.per_active(per_active), .per_src(per_src), .per_ext_hz(per_ext_hz),
                         .sua_spi(sua_spi), .sub_spi(sub_spi));

    lpa_arbiter u_dut (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req_mode(req_mode),
        .irq_pend(irq_pend), .irq_exit(irq_exit), .per_active(per_active), .per_src(per_src),
        .per_ext_hz(per_ext_hz), .sua_spi(sua_spi), .sub_spi(sub_spi), .dma_trig(dma_trig),
        .dma_done(dma_done), .crc_busy(busy[0]), .mul_busy(busy[1]), .aes_busy(busy[2]),
        .cur_mode(cur_mode), .in_isr(in_isr), .dma_xfer(dma_xfer), .entry_hold(entry_hold),
        .group_pwr(group_pwr));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : check

    // Fresh start per scenario keeps one request in flight
    task automatic do_reset();
        rstn = 1'b0;
        u_per.clear_all();
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
    endtask : do_reset

    // Pulse taken at c0, grant visible after c1
    task automatic request(input lpa_mode_t m);
        req_mode  = m;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : request

    task automatic wait_mode(input lpa_mode_t m);
        for (int i = 0; i < 6 && cur_mode !== m; i++) begin
            @(negedge sys_clk);
        end
        check("cur_mode", cur_mode, m);
    endtask : wait_mode

    task automatic t_classes();
        for (int i = 0; i < 16; i++) begin
            do_reset();
            u_per.set_slot(c_slot[i], 3'(c_src[i]), c_hz[i]);
            request(lpa_mode_t'(c_req[i]));
            check("cur_mode", cur_mode, 8'(c_exp[i]));
        end
        $display("test classes done");
    endtask : t_classes

    task automatic t_busy();
        for (int b = 0; b < 3; b++) begin
            do_reset();
            u_per.set_slot(7, LPA_SRC_VLO, 0);
            busy = 3'(1 << b);
            request(LPA_OFF4);
            check("cur_mode", cur_mode, LPA_ACTIVE);
            check("entry_hold", entry_hold, 1'b1);
            busy = 3'h0;
            wait_mode(LPA_STBY3);
            check("entry_hold", entry_hold, 1'b0);
            check("group_pwr", group_pwr, 4'h8);
        end
        $display("test busy done");
    endtask : t_busy

    task automatic t_dma();
        do_reset();
        u_per.set_slot(0, LPA_SRC_AUX, 0);
        request(LPA_OFF4);
        check("cur_mode", cur_mode, LPA_STBY3);
        dma_trig = 1'b1;
        @(negedge sys_clk);
        dma_trig = 1'b0;
        check("cur_mode", cur_mode, LPA_ACTIVE);
        check("dma_xfer", dma_xfer, 1'b1);
        @(negedge sys_clk);
        check("cur_mode", cur_mode, LPA_ACTIVE);
        dma_done = 1'b1;
        @(negedge sys_clk);
        dma_done = 1'b0;
        wait_mode(LPA_STBY3);
        check("dma_xfer", dma_xfer, 1'b0);
        $display("test dma done");
    endtask : t_dma

    task automatic t_irq();
        do_reset();
        u_per.set_slot(5, LPA_SRC_WAIT, 0);
        request(LPA_OFF4);
        check("cur_mode", cur_mode, LPA_OFF4);
        irq_pend = 1'b1;
        @(negedge sys_clk);
        irq_pend = 1'b0;
        check("cur_mode", cur_mode, LPA_ACTIVE);
        check("in_isr", in_isr, 1'b1);
        request(LPA_STBY2);
        check("cur_mode", cur_mode, LPA_ACTIVE);
        irq_exit = 1'b1;
        @(negedge sys_clk);
        irq_exit = 1'b0;
        wait_mode(LPA_OFF4);
        check("in_isr", in_isr, 1'b0);
        check("group_pwr", group_pwr, 4'h1);
        irq_pend = 1'b1;
        dma_trig = 1'b1;
        @(negedge sys_clk);
        irq_pend = 1'b0;
        dma_trig = 1'b0;
        check("in_isr", in_isr, 1'b1);
        check("dma_xfer", dma_xfer, 1'b0);
        $display("test irq done");
    endtask : t_irq

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20) @(negedge sys_clk);
        rstn = 1'b1;
        t_classes();
        t_busy();
        t_dma();
        t_irq();
        wrap_up();
    end

    // Whole run is about 140 cycles; allow ample margin
    initial begin
        #500000;
        mismatches++;
        wrap_up();
    end
endmodule : tb
